/* bench/peprot_feed_model.sv */
/*
  host reference source and encoder feedback: one-cycle delta pulses.
  assumes the bench calls put right after a clock edge.
*/
module peprot_feed_model (
  input wire logic clk,
  output logic refValid,
  output logic signed [15:0] refDelta,
  output logic fbValid,
  output logic signed [15:0] fbDelta
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    refValid = 1'b0;
    fbValid = 1'b0;
    refDelta = 16'sh0;
    fbDelta = 16'sh0;
  end
  // idle deltas are inverted so a stale value never looks valid
  task automatic put(input logic isFb, input logic signed [15:0] d);
    @(posedge clk);
    if (isFb) begin
      fbValid <= 1'b1;
      fbDelta <= d;
    end else begin
      refValid <= 1'b1;
      refDelta <= d;
    end
    @(posedge clk);
    fbValid <= 1'b0;
    refValid <= 1'b0;
    fbDelta <= ~fbDelta;
    refDelta <= ~refDelta;
  endtask : put
endmodule : peprot_feed_model

/* bench/peprot_props.sv */
/*
  checker for peprot_top: apb timing, stop path and alarm latching at the ports.
  assumes one clk domain; bound onto every peprot_top.
*/
module peprot_props (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [1:0] ctrlMode,
  input wire logic motorPowerOn,
  input wire logic signed [15:0] speedOut,
  input wire logic signed [15:0] torqueOut,
  input wire logic motorStop,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // warm-up
  // ----------------------------------------
  // the internal reset lags arst_n by two edges, so checks wait a little longer
  logic [2:0] upCnt_ff;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) upCnt_ff <= 3'h0;
    else if (upCnt_ff != 3'h5) upCnt_ff <= upCnt_ff + 3'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n || upCnt_ff != 3'h5);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  setup_ready_a: assert property (psel && !penable |=> pready) else $error("no pready after setup");
  ready_access_a: assert property (pready |-> psel && penable) else $error("pready outside access");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero when idle");
  power_stop_a: assert property (!motorPowerOn |=> motorStop) else $error("no stop with power off");
  stop_zero_a: assert property (motorStop [*2] |-> speedOut == 16'sh0 && torqueOut == 16'sh0)
    else $error("outputs not zero while stopped");
  mode_guard_a: assert property (!motorStop && motorPowerOn && ctrlMode != 2'h1 && $past(ctrlMode) != 2'h1
    |=> !motorStop) else $error("stop outside position mode");
  alarm_latch_a: assert property (motorStop && motorPowerOn && $past(motorPowerOn) && !(psel && pwrite)
    && !$past(psel && pwrite) |=> motorStop) else $error("alarm stop released without clear");
  cover property (motorStop && motorPowerOn);
  cover property (irq);
  cover property (pslverr);
endmodule : peprot_props

bind peprot_top peprot_props u_peprot_props (.clk, .arst_n, .psel, .penable, .pwrite, .prdata, .pready,
  .pslverr, .ctrlMode, .motorPowerOn, .speedOut, .torqueOut, .motorStop, .irq);

/* bench/peprot_top_test.sv */
/*
  self-checking bench for peprot_top with random and corner stimulus.
  assumes the feed model and checker compile first.
*/
`include "peprot_params.svh"
module peprot_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, motorPowerOn = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd, v;
  logic pready, pslverr, se, motorStop, irq, refValid, fbValid;
  logic [1:0] ctrlMode = 2'h0;
  logic signed [15:0] refDelta, fbDelta, speedOut, torqueOut, t, speedCmd = 16'sh0, torqueCmd = 16'sh0;
  int errCount = 0, checked = 0, expErr = 0;
  logic [11:0] ofs[4] = '{`PEP_OFS_ALARM_LVL, `PEP_OFS_SON_ALARM_LVL, `PEP_OFS_SON_WARN_LVL, `PEP_OFS_SON_SPD_LIM};
  logic [31:0] lo[4] = '{1, 1, 10, 0};
  logic [31:0] hi[4] = '{32'h3fffffff, 32'h3fffffff, 100, 10000};
  logic [31:0] rst[4] = '{5242880, 5242880, 100, 10000};
  always #25 clk = ~clk;
  peprot_top u_peprot_top (.clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .ctrlMode, .motorPowerOn, .refValid, .refDelta, .fbValid, .fbDelta, .speedCmd, .torqueCmd, .speedOut,
    .torqueOut, .motorStop, .irq);
  peprot_feed_model u_peprot_feed_model (.clk, .refValid, .refDelta, .fbValid, .fbDelta);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic stop_test;
    if (errCount == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errCount++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) errCount++;
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic feed(input logic isFb, input int d);
    u_peprot_feed_model.put(isFb, 16'(d));
    expErr += isFb ? -d : d;
  endtask : feed
  function automatic logic [31:0] sat(input logic [31:0] x, input logic [31:0] l, input logic [31:0] h);
    return x < l ? l : x > h ? h : x;
  endfunction : sat
  function automatic logic signed [15:0] clampv(input int x, input int l);
    return 16'(x > l ? l : x < -l ? -l : x);
  endfunction : clampv
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    void'($urandom(32'hc1d9ba10));
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      apb(0, ofs[i], 0);
      chk(rd, rst[i]);
      for (int k = 0; k < 3; k++) begin
        v = k == 0 ? 32'h0 : k == 1 ? 32'hffffffff : $urandom % (hi[i] + 2);
        apb(1, ofs[i], v);
        apb(0, ofs[i], 0);
        chk(rd, sat(v, lo[i], hi[i]));
      end
    end
    apb(0, 12'h02c, 0);
    chk({rd[30:0], se}, 32'h1);
    // level: steady error of 50 from the loop gain (no model following) times a margin of 2
    apb(1, `PEP_OFS_ALARM_LVL, 50 * 2);
    apb(1, `PEP_OFS_SON_ALARM_LVL, 50);
    apb(1, `PEP_OFS_SON_WARN_LVL, 100);
    repeat (8) feed($urandom_range(0, 1), $urandom_range(0, 200) - 100);
    apb(0, `PEP_OFS_ERR_CNT, 0);
    chk(rd, expErr);
    feed(1, expErr);
    motorPowerOn <= 1'b1;
    speedCmd <= 16'($urandom_range(1, 5000));
    feed(0, 500);
    repeat (6) @(posedge clk);
    chk(motorStop, 0);
    chk(speedOut, speedCmd);
    feed(1, 500);
    apb(1, `PEP_OFS_IRQ_CLR, 32'hf);
    apb(1, `PEP_OFS_IRQ_EN, 32'hf);
    ctrlMode <= 2'h1;
    feed(0, 300);
    repeat (6) @(posedge clk);
    chk({motorStop, irq, speedOut}, 18'h30000);
    apb(0, `PEP_OFS_IRQ_STAT, 0);
    chk(rd[0], 1);
    feed(1, 300);
    repeat (6) @(posedge clk);
    chk(motorStop, 1);
    apb(1, `PEP_OFS_CTRL, 1);
    apb(1, `PEP_OFS_IRQ_CLR, 32'hf);
    repeat (4) @(posedge clk);
    chk({motorStop, irq}, 0);
    motorPowerOn <= 1'b0;
    feed(0, 80);
    apb(0, `PEP_OFS_STATUS, 0);
    chk(rd[3:0], 4'hc);
    motorPowerOn <= 1'b1;
    repeat (6) @(posedge clk);
    apb(0, `PEP_OFS_IRQ_STAT, 0);
    chk({rd[1], motorStop, irq}, 3'h7);
    apb(1, `PEP_OFS_IRQ_EN, 0);
    repeat (2) @(posedge clk);
    chk(irq, 0);
    feed(1, 80);
    apb(1, `PEP_OFS_CTRL, 1);
    apb(1, `PEP_OFS_SON_SPD_LIM, 100);
    motorPowerOn <= 1'b0;
    feed(0, 30);
    speedCmd <= 16'sd3000;
    motorPowerOn <= 1'b1;
    repeat (4) @(posedge clk);
    chk(speedOut, 100);
    apb(0, `PEP_OFS_STATUS, 0);
    chk(rd[1], 1);
    feed(0, 200);
    feed(0, 200);
    repeat (4) @(posedge clk);
    apb(0, `PEP_OFS_IRQ_STAT, 0);
    chk(rd[2], 1);
    feed(1, expErr);
    ctrlMode <= 2'h0;
    apb(1, `PEP_OFS_CTRL, 1);
    apb(1, `PEP_OFS_TRQ_LIM, 500);
    for (int i = 0; i < 5; i++) begin
      t = i == 0 ? -16'sd2000 : 16'($urandom_range(0, 4000) - 2000);
      torqueCmd <= t;
      repeat (3) @(posedge clk);
      chk(torqueOut, clampv(t, 500));
    end
    stop_test();
  end
  initial begin
    repeat (40000) @(posedge clk);
    errCount++;
    stop_test();
  end
endmodule : peprot_top_test

/* design/peprot_clamp.sv */
/*
  symmetric saturating limiter: result stays within plus or minus limit.
  assumes limit is an unsigned magnitude.
*/
module peprot_clamp (
  peprot_clamp_if.lim bus
);
  logic signed [16:0] lim17;
  logic signed [16:0] val17;
  assign lim17 = {1'b0, bus.limit};
  assign val17 = {bus.value[15], bus.value};
  always_comb begin
    if (val17 > lim17) begin
      bus.result = lim17[15:0];
    end else if (val17 < -lim17) begin
      bus.result = 16'((-lim17));
    end else begin
      bus.result = bus.value;
    end
  end
endmodule : peprot_clamp

/* design/peprot_clamp_if.sv */
/*
  clamp bundle between the protection top and its saturating limiter.
  assumes one clock domain.
*/
interface peprot_clamp_if;
  logic signed [15:0] value;
  logic [15:0] limit;
  logic signed [15:0] result;
  modport top(output value, output limit, input result);
  modport lim(input value, input limit, output result);
endinterface : peprot_clamp_if

/* design/peprot_params.svh */
/*
  position error protection constants: offsets, field positions, reset values, limits.
  assumes inclusion by bare name from design files and from the bench.
*/
`ifndef PEPROT_PARAMS_SVH
`define PEPROT_PARAMS_SVH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define PEP_OFS_CTRL 12'h000
`define PEP_OFS_ALARM_LVL 12'h004
`define PEP_OFS_SON_ALARM_LVL 12'h008
`define PEP_OFS_SON_WARN_LVL 12'h00c
`define PEP_OFS_SON_SPD_LIM 12'h010
`define PEP_OFS_TRQ_LIM 12'h014
`define PEP_OFS_ERR_CNT 12'h018
`define PEP_OFS_STATUS 12'h01c
`define PEP_OFS_IRQ_STAT 12'h020
`define PEP_OFS_IRQ_EN 12'h024
`define PEP_OFS_IRQ_CLR 12'h028
// ----------------------------------------
// fields
// ----------------------------------------
`define PEP_CTRL_ALM_CLR 0
`define PEP_ST_MOTOR_ON 0
`define PEP_ST_CLAMP 1
`define PEP_ST_WARN 2
`define PEP_ST_STOP 3
`define PEP_EV_POS_OVF 0
`define PEP_EV_SON_OVF 1
`define PEP_EV_SPD_OVF 2
`define PEP_EV_WARN 3
// ----------------------------------------
// reset values and limits
// ----------------------------------------
`define PEP_ALARM_LVL_RST 30'h00500000
`define PEP_ALARM_LVL_MIN 30'h00000001
`define PEP_ALARM_LVL_MAX 30'h3fffffff
`define PEP_WARN_PCT_RST 7'h64
`define PEP_WARN_PCT_MIN 7'h0a
`define PEP_WARN_PCT_MAX 7'h64
`define PEP_SPD_LIM_RST 14'h2710
`define PEP_SPD_LIM_MAX 14'h2710
`define PEP_TRQ_LIM_RST 16'hffff
`endif

/* design/peprot_pkg.sv */
/*
  types shared by the position error protection block.
  assumes nothing of its surroundings.
*/
package peprot_pkg;
  typedef enum logic [1:0] {CM_SPEED, CM_POSITION, CM_TORQUE} peprot_mode_t;
  typedef logic signed [31:0] peprot_err_t;
endpackage : peprot_pkg

/* design/peprot_top.sv */
/*
  position error protection: error counter, overflow alarms, servo-on speed clamp, torque clamp, APB slave.
  assumes all inputs synchronous to clk; position deltas arrive as signed counts per valid pulse.
*/
// Functional notes
// - error count is reference minus feedback
// - overflow detection only in position mode
// - error above alarm level raises alarm, stops
// - alarm level 1..1073741823, default 5242880, immediate
// - servo-on with large residual raises alarm
// - warning level 10..100 percent, default 100
// - clamp speed at servo-on, limit 0..10000
// - clamped, new references, over level: alarm
// - drive motor to drain residual error
// - output torque limited to configured maximum
`include "peprot_params.svh"
module peprot_top #(
  parameter int ERR_W = 32
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] ctrlMode,
  input wire logic motorPowerOn,
  input wire logic refValid,
  input wire logic signed [15:0] refDelta,
  input wire logic fbValid,
  input wire logic signed [15:0] fbDelta,
  input wire logic signed [15:0] speedCmd,
  input wire logic signed [15:0] torqueCmd,
  output logic signed [15:0] speedOut,
  output logic signed [15:0] torqueOut,
  output logic motorStop,
  output logic irq
);
  // ----------------------------------------
  // reset synchroniser
  // ----------------------------------------
  logic rstMeta_ff;
  logic rstSync_ff;
  // release is synchronous so no flop leaves reset a cycle before its neighbour
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta_ff <= 1'b0;
      rstSync_ff <= 1'b0;
    end else begin
      rstMeta_ff <= 1'b1;
      rstSync_ff <= rstMeta_ff;
    end
  end
  logic rst_n;
  assign rst_n = rstSync_ff;

  // ----------------------------------------
  // settings
  // ----------------------------------------
  logic [29:0] alarmLvl_ff;
  logic [29:0] sonAlarmLvl_ff;
  logic [6:0] warnPct_ff;
  logic [13:0] spdLim_ff;
  logic [15:0] trqLim_ff;
  logic [3:0] irqStat_ff;
  logic [3:0] irqEn_ff;
  logic [3:0] events;
  logic alarmClr;
  logic wrStb;
  logic [29:0] wrLvl;
  logic [6:0] wrPct;
  logic [13:0] wrSpd;

  assign wrStb = psel && penable && pwrite;
  assign alarmClr = wrStb && (paddr == `PEP_OFS_CTRL) && pwdata[`PEP_CTRL_ALM_CLR];

  // out-of-range writes saturate to the nearest legal value
  always_comb begin
    wrLvl = pwdata[29:0];
    if (pwdata[31:30] != 2'h0) begin
      wrLvl = `PEP_ALARM_LVL_MAX;
    end else if (pwdata[29:0] < `PEP_ALARM_LVL_MIN) begin
      wrLvl = `PEP_ALARM_LVL_MIN;
    end
    wrPct = pwdata[6:0];
    if (pwdata[31:7] != 25'h0 || pwdata[6:0] > `PEP_WARN_PCT_MAX) begin
      wrPct = `PEP_WARN_PCT_MAX;
    end else if (pwdata[6:0] < `PEP_WARN_PCT_MIN) begin
      wrPct = `PEP_WARN_PCT_MIN;
    end
    wrSpd = pwdata[13:0];
    if (pwdata[31:14] != 18'h0 || pwdata[13:0] > `PEP_SPD_LIM_MAX) begin
      wrSpd = `PEP_SPD_LIM_MAX;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alarmLvl_ff <= `PEP_ALARM_LVL_RST;
      sonAlarmLvl_ff <= `PEP_ALARM_LVL_RST;
      warnPct_ff <= `PEP_WARN_PCT_RST;
      spdLim_ff <= `PEP_SPD_LIM_RST;
      trqLim_ff <= `PEP_TRQ_LIM_RST;
      irqEn_ff <= 4'h0;
    end else if (wrStb) begin
      unique case (paddr)
        `PEP_OFS_ALARM_LVL: alarmLvl_ff <= wrLvl;
        `PEP_OFS_SON_ALARM_LVL: sonAlarmLvl_ff <= wrLvl;
        `PEP_OFS_SON_WARN_LVL: warnPct_ff <= wrPct;
        `PEP_OFS_SON_SPD_LIM: spdLim_ff <= wrSpd;
        `PEP_OFS_TRQ_LIM: trqLim_ff <= pwdata[15:0];
        `PEP_OFS_IRQ_EN: irqEn_ff <= pwdata[3:0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // error counter
  // ----------------------------------------
  logic signed [ERR_W-1:0] errCnt_ff;
  logic signed [ERR_W-1:0] nxt_errCnt;
  logic [ERR_W-1:0] errMag;

  // both deltas may land in one cycle; each is sign-extended before use
  always_comb begin
    nxt_errCnt = errCnt_ff;
    if (refValid) begin
      nxt_errCnt = nxt_errCnt + ERR_W'(refDelta);
    end
    if (fbValid) begin
      nxt_errCnt = nxt_errCnt - ERR_W'(fbDelta);
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      errCnt_ff <= '0;
    end else begin
      errCnt_ff <= nxt_errCnt;
    end
  end
  assign errMag = errCnt_ff[ERR_W-1] ? ERR_W'(-errCnt_ff) : ERR_W'(errCnt_ff);

  // ----------------------------------------
  // detection
  // ----------------------------------------
  logic posMode;
  logic overLvl;
  logic overSon;
  logic overWarn;
  logic [37:0] warnThr;
  logic motorOnPrev_ff;
  logic powerEdge;
  logic clamp_ff;
  logic alarmPos_ff;
  logic alarmSon_ff;
  logic alarmSpd_ff;
  logic warn_ff;
  logic alarmAny;

  assign posMode = (ctrlMode == 2'(peprot_pkg::CM_POSITION));
  assign overLvl = errMag > ERR_W'(alarmLvl_ff);
  assign overSon = errMag > ERR_W'(sonAlarmLvl_ff);
  // warning threshold is the servo-on level scaled by percent
  assign warnThr = 38'(sonAlarmLvl_ff) * 38'(warnPct_ff);
  assign overWarn = (38'(errMag) * 38'h64) > warnThr;
  assign powerEdge = motorPowerOn && !motorOnPrev_ff;
  assign alarmAny = alarmPos_ff || alarmSon_ff || alarmSpd_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      motorOnPrev_ff <= 1'b0;
    end else begin
      motorOnPrev_ff <= motorPowerOn;
    end
  end

  // clamp holds from power-on with residual until the counter drains, power drops or position mode is left
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clamp_ff <= 1'b0;
    end else if (!motorPowerOn || !posMode || errCnt_ff == '0) begin
      clamp_ff <= powerEdge && posMode && errCnt_ff != '0;
    end else if (powerEdge) begin
      clamp_ff <= 1'b1;
    end
  end

  // set wins over clear on every alarm latch
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alarmPos_ff <= 1'b0;
    end else if (posMode && motorPowerOn && !clamp_ff && overLvl) begin
      alarmPos_ff <= 1'b1;
    end else if (alarmClr) begin
      alarmPos_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alarmSon_ff <= 1'b0;
    end else if (posMode && powerEdge && overSon) begin
      alarmSon_ff <= 1'b1;
    end else if (alarmClr) begin
      alarmSon_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alarmSpd_ff <= 1'b0;
    end else if (posMode && clamp_ff && refValid && overLvl) begin
      alarmSpd_ff <= 1'b1;
    end else if (alarmClr) begin
      alarmSpd_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      warn_ff <= 1'b0;
    end else begin
      warn_ff <= posMode && !motorPowerOn && overWarn;
    end
  end

  // ----------------------------------------
  // motor output path
  // ----------------------------------------
  peprot_clamp_if spdBus ();
  peprot_clamp_if trqBus ();
  peprot_clamp spdLimiter (.bus(spdBus.lim));
  peprot_clamp trqLimiter (.bus(trqBus.lim));

  // the servo-on clamp lets residual error drain slowly rather than as a sudden lunge
  assign spdBus.value = speedCmd;
  assign spdBus.limit = clamp_ff ? {2'h0, spdLim_ff} : 16'h7fff;
  assign trqBus.value = torqueCmd;
  assign trqBus.limit = trqLim_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      speedOut <= 16'sh0000;
      torqueOut <= 16'sh0000;
      motorStop <= 1'b1;
    end else begin
      motorStop <= alarmAny || !motorPowerOn;
      speedOut <= (alarmAny || !motorPowerOn) ? 16'sh0000 : spdBus.result;
      torqueOut <= (alarmAny || !motorPowerOn) ? 16'sh0000 : trqBus.result;
    end
  end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  logic irqClr;
  logic alarmPos_prev_ff;
  logic alarmSon_prev_ff;
  logic alarmSpd_prev_ff;
  logic warn_prev_ff;
  assign irqClr = wrStb && (paddr == `PEP_OFS_IRQ_CLR);
  // events are rising edges of the latches, so a held alarm fires only once
  assign events[`PEP_EV_POS_OVF] = alarmPos_ff && !alarmPos_prev_ff;
  assign events[`PEP_EV_SON_OVF] = alarmSon_ff && !alarmSon_prev_ff;
  assign events[`PEP_EV_SPD_OVF] = alarmSpd_ff && !alarmSpd_prev_ff;
  assign events[`PEP_EV_WARN] = warn_ff && !warn_prev_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alarmPos_prev_ff <= 1'b0;
      alarmSon_prev_ff <= 1'b0;
      alarmSpd_prev_ff <= 1'b0;
      warn_prev_ff <= 1'b0;
    end else begin
      alarmPos_prev_ff <= alarmPos_ff;
      alarmSon_prev_ff <= alarmSon_ff;
      alarmSpd_prev_ff <= alarmSpd_ff;
      warn_prev_ff <= warn_ff;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqStat_ff <= 4'h0;
    end else begin
      irqStat_ff <= events | (irqStat_ff & ~(irqClr ? pwdata[3:0] : 4'h0));
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStat_ff & irqEn_ff);
    end
  end

  // ----------------------------------------
  // apb read side
  // ----------------------------------------
  logic [31:0] rdMux;
  logic addrOk;
  // unmapped offsets answer with pslverr and read as zero
  always_comb begin
    rdMux = 32'h0;
    addrOk = 1'b1;
    unique case (paddr)
      `PEP_OFS_CTRL: rdMux = 32'h0;
      `PEP_OFS_ALARM_LVL: rdMux = {2'h0, alarmLvl_ff};
      `PEP_OFS_SON_ALARM_LVL: rdMux = {2'h0, sonAlarmLvl_ff};
      `PEP_OFS_SON_WARN_LVL: rdMux = {25'h0, warnPct_ff};
      `PEP_OFS_SON_SPD_LIM: rdMux = {18'h0, spdLim_ff};
      `PEP_OFS_TRQ_LIM: rdMux = {16'h0, trqLim_ff};
      `PEP_OFS_ERR_CNT: rdMux = 32'(errCnt_ff);
      `PEP_OFS_STATUS: rdMux = {28'h0, motorStop, warn_ff, clamp_ff, motorPowerOn};
      `PEP_OFS_IRQ_STAT: rdMux = {28'h0, irqStat_ff};
      `PEP_OFS_IRQ_EN: rdMux = {28'h0, irqEn_ff};
      `PEP_OFS_IRQ_CLR: rdMux = 32'h0;
      default: addrOk = 1'b0;
    endcase
  end

  // zero-wait slave: pready is a flop loaded in the setup cycle, so it is high in the access cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addrOk;
      prdata <= (psel && !penable && !pwrite) ? rdMux : 32'h0;
    end
  end
endmodule : peprot_top
